/* File: hw/clock_config_map.vh */
// Register map, field positions and power-up image of the clock configuration block
`ifndef CLOCK_CONFIG_MAP_VH
`define CLOCK_CONFIG_MAP_VH

// Register byte offsets
`define OFS_SYNTH1_SET0   8'h00
`define OFS_SYNTH1_SET1   8'h04
`define OFS_SYNTH2_CFG    8'h08
`define OFS_SYNTH3_CFG    8'h0C
`define OFS_ROUTE_CFG     8'h10
`define OFS_DIV_A         8'h14
`define OFS_DIV_B         8'h18
`define OFS_DIV_C         8'h1C
`define OFS_PIN_CFG       8'h20
`define OFS_XTAL_CFG      8'h24
`define OFS_STATUS        8'h28

// Synthesizer word: pre-divider and feedback multiplier
`define SYN_Q_LSB         0
`define SYN_P_LSB         8
// Route word: 2-bit source per output, inverted-phase bits
`define RT_SRC_LSB        0
`define RT_INV_LSB        8
// Divider word: setting 0 and setting 1
`define DIV0_LSB          0
`define DIV1_LSB          8
// Pin word: function, extra suspend with select, suspend sets
`define PIN_FUNC_LSB      0
`define PIN_FS_SUSP_BIT   2
`define PIN_SMASK_LSB     4
`define PIN_OMASK_LSB     8
// Crystal word: load code, bypass, drive
`define XT_CAP_LSB        0
`define XT_BYPASS_BIT     8
`define XT_DRIVE_LSB      12

// Pin function codes
`define FUNC_FSEL         2'h0
`define FUNC_SUSPEND      2'h1
`define FUNC_OE           2'h2
`define FUNC_SHUTDOWN     2'h3

// Power-up image of the nonvolatile store
`define RST_SYNTH1_SET0   32'h0000_0801
`define RST_SYNTH1_SET1   32'h0000_1001
`define RST_SYNTH2_CFG    32'h0000_0801
`define RST_SYNTH3_CFG    32'h0000_0801
`define RST_ROUTE_CFG     32'h0000_0000
`define RST_DIV_A         32'h0000_0402
`define RST_DIV_B         32'h0000_0402
`define RST_DIV_C         32'h0000_0002
`define RST_PIN_CFG       32'h0000_0002
`define RST_XTAL_CFG      32'h0000_1000

`endif

/* File: hw/three_pll_clock_config.v */
// Configuration, crosspoint, post dividers and pin control of a three-synthesizer clock generator
// Functional notes
// - Synth rate is reference over Q times P
// - Four sources routable to any output
// - Each output has own seven-bit post divider
// - Outputs A and B pick divider by select
// - Output C uses one divider value only
// - Input pin takes one of four functions
// - Select picks synth one, B, A settings
// - Divider changes applied glitch free
// - Output enable low floats all outputs
// - Shutdown low floats outputs, stops everything
// - After shutdown synth-fed outputs wait for relock
// - Suspend low disables configured synths, outputs
// - Suspended synth stopped, suspended output floats
// - Suspend may act alongside frequency select
// - Six-bit crystal load code, 0.375pF steps
// - Bypass option removes crystal load capacitors
// - Oscillator drive strength is configurable
// - Inverted synth phase selectable per output
`timescale 1ns/10ps
`default_nettype none
`include "clock_config_map.vh"

module three_pll_clock_config #(
  parameter Q_W     = 8,
  parameter P_W     = 11,
  parameter DIV_W   = 7,
  parameter CAP_W   = 6,
  parameter DRIVE_W = 2
) (
  // Clock and reset
  input  wire                   clk,
  input  wire                   rst,
  // APB slave
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [7:0]             paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output wire                   pready,
  output wire                   pslverr,
  // Multi-function input pin
  input  wire                   gp_pin,
  // Synthesizer control and feedback
  output reg  [3*Q_W-1:0]       synth_q,
  output reg  [3*P_W-1:0]       synth_p,
  output reg  [2:0]             synth_en,
  input  wire [2:0]             synth_lock,
  input  wire [2:0]             synth_tick,
  // Oscillator control
  output reg                    osc_en,
  output reg  [CAP_W-1:0]       xtal_cap,
  output reg                    xtal_bypass,
  output reg  [DRIVE_W-1:0]     xtal_drive,
  // Clock outputs: first, second, third
  output reg  [2:0]             output_clock,
  output reg  [2:0]             output_clock_oe
);

  // Configuration store
  reg  [31:0] syn1_s0_q;
  reg  [31:0] syn1_s1_q;
  reg  [31:0] syn2_q;
  reg  [31:0] syn3_q;
  reg  [31:0] route_q;
  reg  [31:0] div_a_q;
  reg  [31:0] div_b_q;
  reg  [31:0] div_c_q;
  reg  [31:0] pin_q;
  reg  [31:0] xtal_q;
  // Pin sampling
  reg         pin_q1;
  reg         fs_sel_q;

  // Bus handshake
  wire setup_ph  = psel & ~penable;
  wire access_ph = psel & penable;
  reg  addr_hit;

  // Address decode
  always @* begin
    case (paddr)
      `OFS_SYNTH1_SET0, `OFS_SYNTH1_SET1, `OFS_SYNTH2_CFG, `OFS_SYNTH3_CFG,
      `OFS_ROUTE_CFG, `OFS_DIV_A, `OFS_DIV_B, `OFS_DIV_C,
      `OFS_PIN_CFG, `OFS_XTAL_CFG, `OFS_STATUS: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // Zero wait states; unmapped addresses flag an error
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~addr_hit;

  // Pin function decode
  wire [1:0] func     = pin_q[`PIN_FUNC_LSB +: 2];
  wire [2:0] susp_syn = pin_q[`PIN_SMASK_LSB +: 3];
  wire [2:0] susp_out = pin_q[`PIN_OMASK_LSB +: 3];
  wire       fs_use   = (func == `FUNC_FSEL);
  wire       shutdown = (func == `FUNC_SHUTDOWN) & ~pin_q1;
  wire       oe_off   = (func == `FUNC_OE) & ~pin_q1;
  // Suspend also allowed while the pin selects frequency
  wire       suspend  = ((func == `FUNC_SUSPEND) |
                         (fs_use & pin_q[`PIN_FS_SUSP_BIT])) & ~pin_q1;

  // Status word
  wire [31:0] status_w = {21'h00_0000, shutdown, oe_off, suspend,
                          output_clock_oe, synth_lock, fs_sel_q, pin_q1};

  // Read data registered in setup, valid in access phase
  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph & ~pwrite) begin
      case (paddr)
        `OFS_SYNTH1_SET0: prdata <= syn1_s0_q;
        `OFS_SYNTH1_SET1: prdata <= syn1_s1_q;
        `OFS_SYNTH2_CFG:  prdata <= syn2_q;
        `OFS_SYNTH3_CFG:  prdata <= syn3_q;
        `OFS_ROUTE_CFG:   prdata <= route_q;
        `OFS_DIV_A:       prdata <= div_a_q;
        `OFS_DIV_B:       prdata <= div_b_q;
        `OFS_DIV_C:       prdata <= div_c_q;
        `OFS_PIN_CFG:     prdata <= pin_q;
        `OFS_XTAL_CFG:    prdata <= xtal_q;
        `OFS_STATUS:      prdata <= status_w;
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Store loads its power-up image at reset, field writes later
  always @(posedge clk) begin
    if (rst) begin
      syn1_s0_q <= `RST_SYNTH1_SET0;
      syn1_s1_q <= `RST_SYNTH1_SET1;
      syn2_q    <= `RST_SYNTH2_CFG;
      syn3_q    <= `RST_SYNTH3_CFG;
      route_q   <= `RST_ROUTE_CFG;
      div_a_q   <= `RST_DIV_A;
      div_b_q   <= `RST_DIV_B;
      div_c_q   <= `RST_DIV_C;
      pin_q     <= `RST_PIN_CFG;
      xtal_q    <= `RST_XTAL_CFG;
    end else if (access_ph & pwrite) begin
      case (paddr)
        `OFS_SYNTH1_SET0: syn1_s0_q <= pwdata & 32'h0007_FFFF;
        `OFS_SYNTH1_SET1: syn1_s1_q <= pwdata & 32'h0007_FFFF;
        `OFS_SYNTH2_CFG:  syn2_q    <= pwdata & 32'h0007_FFFF;
        `OFS_SYNTH3_CFG:  syn3_q    <= pwdata & 32'h0007_FFFF;
        `OFS_ROUTE_CFG:   route_q   <= pwdata & 32'h0000_073F;
        `OFS_DIV_A:       div_a_q   <= pwdata & 32'h0000_7F7F;
        `OFS_DIV_B:       div_b_q   <= pwdata & 32'h0000_7F7F;
        `OFS_DIV_C:       div_c_q   <= pwdata & 32'h0000_007F;
        `OFS_PIN_CFG:     pin_q     <= pwdata & 32'h0000_0777;
        `OFS_XTAL_CFG:    xtal_q    <= pwdata & 32'h0000_313F;
        default:          pin_q     <= pin_q;
      endcase
    end
  end

  // Pin sample, then select held in a second stage
  always @(posedge clk) begin
    if (rst) begin
      pin_q1   <= 1'b1;
      fs_sel_q <= 1'b0;
    end else begin
      pin_q1   <= gp_pin;
      fs_sel_q <= fs_use & pin_q1;
    end
  end

  // Synthesizer settings; synth one follows the select
  wire [31:0] syn1_w = fs_sel_q ? syn1_s1_q : syn1_s0_q;
  wire [2:0]  syn_run;
  assign syn_run[0] = ~shutdown & ~(suspend & susp_syn[0]);
  assign syn_run[1] = ~shutdown & ~(suspend & susp_syn[1]);
  assign syn_run[2] = ~shutdown & ~(suspend & susp_syn[2]);

  // Analog side control, registered
  always @(posedge clk) begin
    if (rst) begin
      synth_q     <= {3*Q_W{1'b0}};
      synth_p     <= {3*P_W{1'b0}};
      synth_en    <= 3'b000;
      osc_en      <= 1'b1;
      xtal_cap    <= {CAP_W{1'b0}};
      xtal_bypass <= 1'b0;
      xtal_drive  <= {DRIVE_W{1'b0}};
    end else begin
      synth_q     <= {syn3_q[`SYN_Q_LSB +: Q_W], syn2_q[`SYN_Q_LSB +: Q_W],
                      syn1_w[`SYN_Q_LSB +: Q_W]};
      synth_p     <= {syn3_q[`SYN_P_LSB +: P_W], syn2_q[`SYN_P_LSB +: P_W],
                      syn1_w[`SYN_P_LSB +: P_W]};
      synth_en    <= syn_run;
      osc_en      <= ~shutdown;
      xtal_cap    <= xtal_q[`XT_CAP_LSB +: CAP_W];
      xtal_bypass <= xtal_q[`XT_BYPASS_BIT];
      xtal_drive  <= xtal_q[`XT_DRIVE_LSB +: DRIVE_W];
    end
  end

  // Per-output divider value: A and B switch on select, C fixed
  wire [DIV_W-1:0] div_sel [0:2];
  assign div_sel[0] = fs_sel_q ? div_a_q[`DIV1_LSB +: DIV_W] : div_a_q[`DIV0_LSB +: DIV_W];
  assign div_sel[1] = fs_sel_q ? div_b_q[`DIV1_LSB +: DIV_W] : div_b_q[`DIV0_LSB +: DIV_W];
  assign div_sel[2] = div_c_q[`DIV0_LSB +: DIV_W];

  // Output paths
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_out
      reg  [DIV_W-1:0] cnt_q;
      reg  [DIV_W-1:0] n_q;
      reg              ph_q;
      wire [1:0]       src = route_q[`RT_SRC_LSB + 2*g +: 2];
      wire             inv = route_q[`RT_INV_LSB + g];
      reg              tick;
      reg              src_ok;
      wire [DIV_W-1:0] n_eff = (n_q == {DIV_W{1'b0}}) ? {{(DIV_W-1){1'b0}}, 1'b1} : n_q;
      // One extra bit so the largest divide value cannot wrap to zero
      wire [DIV_W:0]   n_inc = {1'b0, n_eff} + {{DIV_W{1'b0}}, 1'b1};
      wire [DIV_W-1:0] half  = n_inc[DIV_W:1];
      wire             last  = (cnt_q == n_eff - {{(DIV_W-1){1'b0}}, 1'b1});
      wire             en_d  = ~shutdown & ~oe_off & ~(suspend & susp_out[g]) & src_ok;

      // Crosspoint: reference ticks every cycle, synths only when locked
      always @* begin
        case (src)
          2'h0:    begin tick = 1'b1;          src_ok = 1'b1; end
          2'h1:    begin tick = synth_tick[0]; src_ok = syn_run[0] & synth_lock[0]; end
          2'h2:    begin tick = synth_tick[1]; src_ok = syn_run[1] & synth_lock[1]; end
          default: begin tick = synth_tick[2]; src_ok = syn_run[2] & synth_lock[2]; end
        endcase
      end

      // Divider; new value taken only at a period boundary
      always @(posedge clk) begin
        if (rst | shutdown) begin
          cnt_q <= {DIV_W{1'b0}};
          n_q   <= div_sel[g];
          ph_q  <= 1'b0;
        end else if (tick & src_ok) begin
          if (last) begin
            cnt_q <= {DIV_W{1'b0}};
            n_q   <= div_sel[g];
          end else begin
            cnt_q <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
          end
          // Divide by one toggles each source edge
          ph_q  <= (n_eff == {{(DIV_W-1){1'b0}}, 1'b1}) ? ~ph_q :
                   (last ? 1'b1 : (cnt_q + {{(DIV_W-1){1'b0}}, 1'b1} < half));
        end
      end

      // Pin drive; enable of a synth-fed output waits for lock after shutdown
      always @(posedge clk) begin
        if (rst) begin
          output_clock[g]    <= 1'b0;
          output_clock_oe[g] <= 1'b0;
        end else begin
          output_clock[g]    <= ph_q ^ (inv & (src != 2'h0));
          output_clock_oe[g] <= en_d;
        end
      end
    end
  endgenerate

endmodule // three_pll_clock_config

`default_nettype wire

/* File: verif/clock_config_sva.sv */
// Port assertions of the clock configuration block
`timescale 1ns/10ps
`default_nettype none
module clock_config_sva (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Power and crystal controls
  input wire logic        osc_en,
  input wire logic [2:0]  synth_en,
  input wire logic [2:0]  output_clock_oe,
  input wire logic [5:0]  xtal_cap,
  input wire logic        xtal_bypass,
  input wire logic [1:0]  xtal_drive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Access phase and crystal word write
  wire logic acc = psel && penable;
  wire logic wx  = acc && pwrite && paddr == 8'h24;
  sequence s_acc; acc; endsequence
  sequence s_bad; acc && paddr > 8'h28; endsequence
  sequence s_good; acc && paddr <= 8'h28 && paddr[1:0] == 2'h0; endsequence
  a_ready_high: assert property (s_acc |-> pready)
    else $error("pready low");
  a_err_unmapped: assert property (s_bad |-> pslverr && (pwrite || prdata == 32'h0000_0000))
    else $error("unmapped access wrong");
  a_err_mapped: assert property (s_good |-> !pslverr)
    else $error("error on mapped access");
  a_err_phase: assert property (pslverr |-> acc)
    else $error("error outside access");
  a_shut_float: assert property (!osc_en |-> output_clock_oe == 3'h0)
    else $error("output driven in shutdown");
  a_shut_stop: assert property (!osc_en |-> synth_en == 3'h0)
    else $error("synth running in shutdown");
  a_cap_hold: assert property (!$past(rst) && !$past(rst, 2) && !$past(wx) && !$past(wx, 2) |->
    $stable(xtal_cap))
    else $error("load code moved");
  a_drive_hold: assert property (!$past(rst) && !$past(rst, 2) && !$past(wx) && !$past(wx, 2) |->
    $stable({xtal_bypass, xtal_drive}))
    else $error("bypass or drive moved");
endmodule // clock_config_sva
bind three_pll_clock_config clock_config_sva i_clock_config_sva (.clk, .rst, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .osc_en, .synth_en, .output_clock_oe, .xtal_cap, .xtal_bypass, .xtal_drive);
`default_nettype wire

/* File: verif/synth_partner.sv */
// Behavioural model of the three synthesizers: relock delay and output ticks
`timescale 1ns/10ps
`default_nettype none
module synth_partner #(
  parameter int LOCK_DLY = 20
) (
  // Clock
  input  wire logic       clk,
  // Synthesizer control and feedback
  input  wire logic [2:0] synth_en,
  output var  logic [2:0] synth_lock,
  output var  logic [2:0] synth_tick
);
  int cnt [3];
  // Lock only after a full settling time, so outputs never look valid early
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      cnt[i] <= synth_en[i] ? (cnt[i] < LOCK_DLY ? cnt[i] + 1 : cnt[i]) : 0;
      synth_lock[i] <= synth_en[i] && cnt[i] >= LOCK_DLY;
      synth_tick[i] <= synth_en[i] && !synth_tick[i];
    end
  end
endmodule // synth_partner
`default_nettype wire

/* File: verif/three_pll_clock_config_tb_top.sv */
// Self-checking bench of the clock configuration block with a register model
`timescale 1ns/10ps
`default_nettype none
`include "clock_config_map.vh"
module three_pll_clock_config_tb_top;
  // Stimulus, responses and model state
  logic        clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, gp_pin = 1'h1, er;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, mdl [10];
  logic        pready, pslverr, osc_en, xtal_bypass;
  logic [23:0] synth_q;
  logic [32:0] synth_p;
  logic [2:0]  synth_en, synth_lock, synth_tick, output_clock, output_clock_oe;
  logic [5:0]  xtal_cap;
  logic [1:0]  xtal_drive;
  int          n_errors = 0, checks = 0;
  localparam logic [31:0] RST [10] = '{`RST_SYNTH1_SET0, `RST_SYNTH1_SET1, `RST_SYNTH2_CFG, `RST_SYNTH3_CFG,
    `RST_ROUTE_CFG, `RST_DIV_A, `RST_DIV_B, `RST_DIV_C, `RST_PIN_CFG, `RST_XTAL_CFG};
  localparam logic [31:0] MSK [10] = '{32'h0007_FFFF, 32'h0007_FFFF, 32'h0007_FFFF, 32'h0007_FFFF,
    32'h0000_073F, 32'h0000_7F7F, 32'h0000_7F7F, 32'h0000_007F, 32'h0000_0777, 32'h0000_313F};

  // Reference clock
  always #20 clk = ~clk;

  three_pll_clock_config i_three_pll_clock_config (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .gp_pin, .synth_q, .synth_p, .synth_en, .synth_lock, .synth_tick, .osc_en, .xtal_cap,
    .xtal_bypass, .xtal_drive, .output_clock, .output_clock_oe);
  synth_partner i_synth_partner (.clk, .synth_en, .synth_lock, .synth_tick);

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, want);
    checks++;
    if (seen !== want) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, want, seen);
    end
  endtask

  // One bus transfer; an idle edge first keeps back-to-back calls race free
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
    if (a < 8'h28) mdl[a[7:2]] = d & MSK[a[7:2]];
  endtask

  task automatic rc(input logic [7:0] a);
    apb(1'h0, a, 32'h0000_0000);
    chk("reg", rd, a < 8'h28 ? mdl[a[7:2]] : 32'h0000_0000);
  endtask

  // Clock periods between rising edges of one output
  task automatic per(input int b, output int p);
    realtime t;
    @(posedge output_clock[b]);
    t = $realtime;
    @(posedge output_clock[b]);
    p = int'(($realtime - t) / 40.0);
  endtask

  // Watchdog: the whole sequence needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict;
  end

  initial begin
    int n0, n1, nc, p;
    void'($urandom(64844));
    for (int i = 0; i < 10; i++) mdl[i] = RST[i];
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 10; i++) rc(8'(i * 4));
    rc(8'h2C);
    chk("err", er, 1);
    for (int i = 0; i < 10; i++) wr(8'(i * 4), $urandom);
    for (int i = 0; i < 10; i++) rc(8'(i * 4));
    repeat (2) @(posedge clk);
    chk("q3", synth_q[23:16], mdl[3][7:0]);
    chk("p3", synth_p[32:22], mdl[3][18:8]);
    chk("xtal", {xtal_drive, xtal_bypass, xtal_cap}, {mdl[9][13:12], mdl[9][8], mdl[9][5:0]});
    // Post dividers on the reference, then a select change in mid-stream
    n0 = $urandom_range(30, 2);
    n1 = $urandom_range(30, 2);
    nc = $urandom_range(30, 2);
    wr(`OFS_ROUTE_CFG, 32'h0000_0000);
    wr(`OFS_PIN_CFG, `FUNC_FSEL);
    wr(`OFS_DIV_A, 32'(n1 << 8 | n0));
    wr(`OFS_DIV_C, 32'(nc));
    gp_pin <= 1'h0;
    per(0, p);
    per(0, p);
    chk("per_a0", p, n0);
    chk("q1_0", synth_q[7:0], mdl[0][7:0]);
    per(2, p);
    chk("per_c", p, nc);
    gp_pin <= 1'h1;
    per(0, p);
    chk("glitch", p == n0 || p == n1, 1);
    per(0, p);
    chk("per_a1", p, n1);
    chk("q1_1", synth_q[7:0], mdl[1][7:0]);
    // Output A from the first synthesizer
    wr(`OFS_ROUTE_CFG, 32'h0000_0001);
    per(0, p);
    per(0, p);
    chk("per_s", p, 2 * n1);
    wr(`OFS_PIN_CFG, `FUNC_OE);
    gp_pin <= 1'h0;
    repeat (5) @(posedge clk);
    chk("oe_off", output_clock_oe, 0);
    gp_pin <= 1'h1;
    repeat (5) @(posedge clk);
    chk("oe_on", output_clock_oe, 7);
    // Suspend alone and alongside select: synth three and the output it feeds
    wr(`OFS_ROUTE_CFG, 32'h0000_0030);
    for (int k = 0; k < 2; k++) begin
      wr(`OFS_PIN_CFG, (k ? 32'h0000_0004 : 32'h0000_0001) | 32'h0000_0440);
      gp_pin <= 1'h0;
      repeat (5) @(posedge clk);
      chk("susp_en", synth_en, 3);
      chk("susp_oe", output_clock_oe, 3);
      gp_pin <= 1'h1;
      repeat (30) @(posedge clk);
      chk("resume", output_clock_oe, 7);
    end
    wr(`OFS_PIN_CFG, `FUNC_SHUTDOWN);
    gp_pin <= 1'h0;
    repeat (5) @(posedge clk);
    chk("shut", {osc_en, synth_en, output_clock_oe}, 0);
    gp_pin <= 1'h1;
    repeat (5) @(posedge clk);
    chk("relock", output_clock_oe, 3);
    repeat (30) @(posedge clk);
    chk("run", output_clock_oe, 7);
    // A and B share synth one and divider; shutdown aligns them, B takes the inverted phase
    wr(`OFS_DIV_B, 32'(n1 << 8 | n0));
    wr(`OFS_ROUTE_CFG, 32'h0000_0235);
    gp_pin <= 1'h0;
    repeat (5) @(posedge clk);
    gp_pin <= 1'h1;
    repeat (40) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      chk("inv", output_clock[1], !output_clock[0]);
    end
    give_verdict;
  end
endmodule // three_pll_clock_config_tb_top
`default_nettype wire
